// *** src/aact_pkg.sv ***
package aact_pkg;
  // ************************************************************
  // Register addresses
  // ************************************************************
  localparam logic [6:0] ADDR_INT_FLAGS = 7'h5F;
  localparam logic [6:0] ADDR_INT_MASKS = 7'h60;
  localparam logic [6:0] ADDR_CTRL_ONE = 7'h61;
  localparam logic [6:0] ADDR_GAIN_LO = 7'h62;
  localparam logic [6:0] ADDR_GAIN_HI = 7'h63;
  localparam logic [6:0] ADDR_VENDOR = 7'h64;
  localparam logic [6:0] ADDR_CC_SIGNED_HI = 7'h65;
  localparam logic [6:0] ADDR_CC_SIGNED_LO = 7'h66;
  localparam logic [6:0] ADDR_CC_RAW_HI = 7'h67;
  localparam logic [6:0] ADDR_CC_RAW_LO = 7'h68;
  localparam logic [6:0] ADDR_RR_BASE = 7'h70;
  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int FLAG_ROUND = 0;
  localparam int FLAG_PEN = 1;
  localparam int FLAG_OVERFLOW = 2;
  localparam int CTL_CC_EN = 3;
  localparam int CTL_CC_CLEAR = 4;
  localparam int CTL_PEN_BIAS = 5;
  localparam int CTL_START = 6;
  localparam int CTL_ENABLE = 7;
  localparam int VND_SUPPLY = 0;
  localparam int VND_CHG_I = 1;
  localparam int VND_BACKUP = 2;
  localparam int VND_BATDET = 3;
  localparam logic [7:0] FLAG_MASK = 8'h07;
  localparam logic [7:0] VND_MASK = 8'h0F;
  localparam logic [7:0] GAIN_HI_MASK = 8'h0F;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] RR_RESET = 8'h1F;
  // ************************************************************
  // Channel numbers and frame layout
  // ************************************************************
  localparam logic [4:0] CH_GP_FIRST = 5'h0A;
  localparam logic [4:0] CH_GP_LAST = 5'h15;
  localparam logic [4:0] CH_TOUCH_LAST = 5'h0D;
  localparam logic [4:0] CH_SUPPLY = 5'h16;
  localparam logic [4:0] CH_CHG_I = 5'h18;
  localparam logic [4:0] CH_BACKUP = 5'h19;
  localparam logic [4:0] CH_BATDET = 5'h1A;
  localparam logic [4:0] CH_STOP = 5'h1F;
  localparam logic [2:0] BIAS_NONE = 3'h0;
  localparam logic [4:0] SPI_ADDR_DONE = 5'h07;
  localparam logic [4:0] SPI_FRAME_DONE = 5'h0F;
  localparam logic [4:0] SPI_SHIFT_FROM = 5'h08;
  typedef enum logic [1:0] {
    AACT_IDLE = 2'b00,
    AACT_SELECT = 2'b01,
    AACT_WAIT = 2'b11
  } aact_state_t;
endpackage

// *** src/aact_top.sv ***
`timescale 1ns/1ps
module aact_top #(
  parameter int RR_ENTRIES = 8
) (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_spi_cs_n,
  input wire logic i_spi_sclk,
  input wire logic i_spi_mosi,
  output logic o_spi_miso,
  output logic o_spi_miso_oe,
  input wire logic i_pen_touch,
  input wire logic i_conv_valid,
  input wire logic [9:0] i_conv_code,
  input wire logic i_cc_pulse,
  input wire logic i_cc_up,
  output logic o_conv_start,
  output logic [4:0] o_chan_sel,
  output logic [2:0] o_bias,
  output logic o_gain_ten,
  output logic o_touch_reference_supply_en,
  output logic o_pen_bias_en,
  output logic [3:0] o_dedicated_en,
  output logic o_result_valid,
  output logic [4:0] o_result_chan,
  output logic [9:0] o_result_code,
  output logic o_result_signed,
  output logic o_result_gain,
  output logic o_int
);
  import aact_pkg::*;

  // Channel permitted by the vendor enables
  function automatic logic chan_enabled(input logic [4:0] ch,
                                        input logic [7:0] vnd);
    case (ch)
      CH_SUPPLY: chan_enabled = vnd[VND_SUPPLY];
      CH_CHG_I: chan_enabled = vnd[VND_CHG_I];
      CH_BACKUP: chan_enabled = vnd[VND_BACKUP];
      CH_BATDET: chan_enabled = vnd[VND_BATDET];
      default: chan_enabled = 1'b1;
    endcase
  endfunction

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  logic [2:0] pin_in;
  logic [2:0] pin_filt_q;
  logic [2:0] sync1_q, sync2_q, sync3_q;
  // Idle pin levels: select high, clock low, no touch
  localparam logic [2:0] PIN_IDLE = 3'b100;
  assign pin_in = {i_spi_cs_n, i_spi_sclk, i_pen_touch};
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_sync
      // Three stages, change taken once two and three agree
      always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
          sync1_q[g] <= PIN_IDLE[g];
          sync2_q[g] <= PIN_IDLE[g];
          sync3_q[g] <= PIN_IDLE[g];
          pin_filt_q[g] <= PIN_IDLE[g]; // No false edge after reset
        end else begin
          sync1_q[g] <= pin_in[g];
          sync2_q[g] <= sync1_q[g];
          sync3_q[g] <= sync2_q[g];
          if (sync2_q[g] == sync3_q[g]) begin
            pin_filt_q[g] <= sync3_q[g];
          end
        end
      end
    end
  endgenerate
  logic mosi1_q, mosi2_q, mosi3_q, mosi_q;
  // Data pin synchroniser
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      mosi1_q <= 1'b0;
      mosi2_q <= 1'b0;
      mosi3_q <= 1'b0;
      mosi_q <= 1'b0;
    end else begin
      mosi1_q <= i_spi_mosi;
      mosi2_q <= mosi1_q;
      mosi3_q <= mosi2_q;
      if (mosi2_q == mosi3_q) begin
        mosi_q <= mosi3_q;
      end
    end
  end

  // ************************************************************
  // SPI slave, mode 0, 16-bit frames
  // ************************************************************
  logic cs_act, sclk_prev_q, sclk_rise, sclk_fall, pen_f;
  logic [4:0] bit_cnt_q;
  logic [14:0] shift_in_q;
  logic [7:0] shift_out_q, rd_data, wr_data;
  logic [6:0] addr_q;
  logic rd_q, rd_stb, wr_stb;
  assign cs_act = ~pin_filt_q[2];
  assign pen_f = pin_filt_q[0];
  assign sclk_rise = cs_act & pin_filt_q[1] & ~sclk_prev_q;
  assign sclk_fall = cs_act & ~pin_filt_q[1] & sclk_prev_q;
  assign rd_stb = sclk_rise & (bit_cnt_q == SPI_ADDR_DONE)
                  & shift_in_q[6];
  assign wr_stb = sclk_rise & (bit_cnt_q == SPI_FRAME_DONE) & ~rd_q;
  assign wr_data = {shift_in_q[6:0], mosi_q};
  // Bit counter and receive shifter
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      sclk_prev_q <= 1'b0;
      bit_cnt_q <= 5'h00;
      shift_in_q <= 15'h0000;
      addr_q <= 7'h00;
      rd_q <= 1'b0;
    end else begin
      sclk_prev_q <= pin_filt_q[1];
      if (!cs_act) begin
        bit_cnt_q <= 5'h00;
      end else if (sclk_rise) begin
        shift_in_q <= {shift_in_q[13:0], mosi_q};
        bit_cnt_q <= bit_cnt_q + 5'h01;
        if (bit_cnt_q == SPI_ADDR_DONE) begin
          rd_q <= shift_in_q[6];
          addr_q <= {shift_in_q[5:0], mosi_q};
        end
      end
    end
  end

  // ************************************************************
  // Registers
  // ************************************************************
  logic [7:0] flags_q, masks_q, ctrl_q, gain_lo_q, gain_hi_q, vnd_q;
  logic [7:0] rr_q [RR_ENTRIES];
  logic [15:0] cc_q;
  logic [7:0] snap_signed_q, snap_raw_q;
  logic cc14_prev_q, round_set, pen_set, ovf_set;
  logic [6:0] rd_addr;
  assign rd_addr = {shift_in_q[5:0], mosi_q};
  assign pen_set = ctrl_q[CTL_PEN_BIAS] & pen_f;
  assign ovf_set = cc_q[14] & ~cc14_prev_q;
  // Writable control registers
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      masks_q <= RESET_BYTE;
      ctrl_q <= RESET_BYTE;
      gain_lo_q <= RESET_BYTE;
      gain_hi_q <= RESET_BYTE;
      vnd_q <= RESET_BYTE;
    end else begin
      ctrl_q[CTL_CC_CLEAR] <= 1'b0; // Self clearing
      if (wr_stb) begin
        case (addr_q)
          ADDR_INT_MASKS: masks_q <= wr_data & FLAG_MASK;
          ADDR_CTRL_ONE: ctrl_q <= wr_data;
          ADDR_GAIN_LO: gain_lo_q <= wr_data;
          ADDR_GAIN_HI: gain_hi_q <= wr_data & GAIN_HI_MASK;
          ADDR_VENDOR: vnd_q <= wr_data & VND_MASK;
          default: ;
        endcase
      end
    end
  end
  // Round robin address entries
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      for (int i = 0; i < RR_ENTRIES; i++) begin
        rr_q[i] <= RR_RESET;
      end
    end else if (wr_stb && addr_q >= ADDR_RR_BASE
                 && addr_q < ADDR_RR_BASE + 7'(RR_ENTRIES)) begin
      rr_q[3'(addr_q - ADDR_RR_BASE)] <= wr_data;
    end
  end
  // Sticky flags, write one to clear, set wins
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      flags_q <= RESET_BYTE;
      cc14_prev_q <= 1'b0;
    end else begin
      cc14_prev_q <= cc_q[14];
      flags_q <= ((wr_stb && addr_q == ADDR_INT_FLAGS) ?
                  (flags_q & ~wr_data) : flags_q)
                 | {5'h00, ovf_set, pen_set, round_set};
    end
  end
  // Charge counter
  always_ff @(posedge i_sys_clk) begin
    if (i_reset || ctrl_q[CTL_CC_CLEAR]) begin
      cc_q <= 16'h0000;
    end else if (ctrl_q[CTL_CC_EN] && i_cc_pulse) begin
      cc_q <= i_cc_up ? cc_q + 16'h0001 : cc_q - 16'h0001;
    end
  end
  // Low byte snapshots on high byte reads
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      snap_signed_q <= RESET_BYTE;
      snap_raw_q <= RESET_BYTE;
    end else if (rd_stb) begin
      if (rd_addr == ADDR_CC_SIGNED_HI) begin
        snap_signed_q <= cc_q[7:0];
      end
      if (rd_addr == ADDR_CC_RAW_HI) begin
        snap_raw_q <= cc_q[7:0];
      end
    end
  end
  // Read data select
  always_comb begin
    rd_data = RESET_BYTE;
    case (rd_addr)
      ADDR_INT_FLAGS: rd_data = flags_q;
      ADDR_INT_MASKS: rd_data = masks_q;
      ADDR_CTRL_ONE: rd_data = ctrl_q;
      ADDR_GAIN_LO: rd_data = gain_lo_q;
      ADDR_GAIN_HI: rd_data = gain_hi_q;
      ADDR_VENDOR: rd_data = vnd_q;
      ADDR_CC_SIGNED_HI: rd_data = cc_q[15:8];
      ADDR_CC_SIGNED_LO: rd_data = snap_signed_q;
      ADDR_CC_RAW_HI: rd_data = cc_q[15:8];
      ADDR_CC_RAW_LO: rd_data = snap_raw_q;
      default: begin
        if (rd_addr >= ADDR_RR_BASE
            && rd_addr < ADDR_RR_BASE + 7'(RR_ENTRIES)) begin
          rd_data = rr_q[3'(rd_addr - ADDR_RR_BASE)];
        end
      end
    endcase
  end
  // Transmit shifter, data out MSB first
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      shift_out_q <= RESET_BYTE;
      o_spi_miso <= 1'b0;
      o_spi_miso_oe <= 1'b0;
    end else begin
      if (rd_stb) begin
        shift_out_q <= rd_data;
      end else if (sclk_fall && bit_cnt_q > SPI_SHIFT_FROM) begin
        shift_out_q <= {shift_out_q[6:0], 1'b0};
      end
      o_spi_miso <= shift_out_q[7];
      o_spi_miso_oe <= cs_act;
    end
  end

  // ************************************************************
  // Round robin sequencer
  // ************************************************************
  aact_state_t state_q;
  logic [2:0] idx_q;
  logic [7:0] entry;
  logic [4:0] ent_ch;
  logic [2:0] ent_bias;
  logic last_idx, gp_gain, run;
  assign entry = rr_q[idx_q];
  assign ent_ch = entry[4:0];
  assign ent_bias = entry[7:5];
  assign last_idx = (idx_q == 3'(RR_ENTRIES - 1));
  assign run = ctrl_q[CTL_ENABLE];
  assign round_set = (state_q == AACT_SELECT)
                     && (ent_ch == CH_STOP || last_idx);
  logic [11:0] gain_bits;
  assign gain_bits = {gain_hi_q[3:0], gain_lo_q};
  // Gain bit of the selected general channel
  always_comb begin
    gp_gain = 1'b0;
    if (ent_ch >= CH_GP_FIRST && ent_ch <= CH_GP_LAST) begin
      gp_gain = gain_bits[4'(ent_ch - CH_GP_FIRST)];
      if (ent_ch <= CH_TOUCH_LAST && ent_bias != BIAS_NONE) begin
        gp_gain = 1'b0;
      end
    end
  end
  // Sequencer state and index
  always_ff @(posedge i_sys_clk) begin
    if (i_reset || !run) begin
      state_q <= AACT_IDLE;
      idx_q <= 3'h0;
    end else begin
      case (state_q)
        AACT_IDLE: begin
          if (ctrl_q[CTL_START]) begin
            state_q <= AACT_SELECT;
            idx_q <= 3'h0;
          end
        end
        AACT_SELECT: begin
          if (round_set) begin
            idx_q <= 3'h0;
            state_q <= ctrl_q[CTL_START] ? AACT_SELECT : AACT_IDLE;
          end else if (!chan_enabled(ent_ch, vnd_q)) begin
            idx_q <= idx_q + 3'h1;
          end else begin
            state_q <= AACT_WAIT;
          end
        end
        AACT_WAIT: begin
          if (i_conv_valid) begin
            idx_q <= idx_q + 3'h1;
            state_q <= AACT_SELECT;
          end
        end
        default: state_q <= AACT_IDLE;
      endcase
    end
  end
  logic start_now;
  assign start_now = (state_q == AACT_SELECT) && !round_set
                     && chan_enabled(ent_ch, vnd_q);
  // Converter steering outputs
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_conv_start <= 1'b0;
      o_chan_sel <= CH_STOP;
      o_bias <= BIAS_NONE;
      o_gain_ten <= 1'b0;
      o_touch_reference_supply_en <= 1'b0;
      o_pen_bias_en <= 1'b0;
      o_dedicated_en <= 4'h0;
    end else begin
      o_conv_start <= start_now && run;
      o_pen_bias_en <= ctrl_q[CTL_PEN_BIAS];
      o_dedicated_en <= vnd_q[3:0];
      if (start_now && run) begin
        o_chan_sel <= ent_ch;
        o_bias <= ent_bias;
        o_gain_ten <= gp_gain;
        o_touch_reference_supply_en <= (ent_bias != BIAS_NONE);
      end
    end
  end
  // Conversion results, codes passed as delivered
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_result_valid <= 1'b0;
      o_result_chan <= 5'h00;
      o_result_code <= 10'h000;
      o_result_signed <= 1'b0;
      o_result_gain <= 1'b0;
    end else begin
      o_result_valid <= (state_q == AACT_WAIT) && i_conv_valid;
      if (state_q == AACT_WAIT && i_conv_valid) begin
        o_result_chan <= o_chan_sel;
        o_result_code <= i_conv_code;
        o_result_signed <= (o_chan_sel == CH_CHG_I);
        o_result_gain <= o_gain_ten;
      end
    end
  end
  // Interrupt raised at the next conversion start
  always_ff @(posedge i_sys_clk) begin
    if (i_reset || !(|(flags_q & ~masks_q))) begin
      o_int <= 1'b0;
    end else if (start_now && run) begin
      o_int <= 1'b1;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);
  chk_pen_flag_set: assert property (pen_set |=> flags_q[FLAG_PEN])
    else $error("pen flag not set");
  chk_int_masked: assert property (
    !(|(flags_q & ~masks_q)) |=> !o_int)
    else $error("interrupt while masked");
  chk_skip_disabled: assert property (
    state_q == AACT_SELECT && ent_ch == CH_SUPPLY && !vnd_q[VND_SUPPLY]
    |=> !o_conv_start ##1 !o_conv_start)
    else $error("disabled channel converted");
  chk_stop_round: assert property (
    state_q == AACT_SELECT && ent_ch == CH_STOP
    |=> flags_q[FLAG_ROUND] && !o_conv_start)
    else $error("stop code ignored");
  chk_cc_step: assert property (
    ctrl_q[CTL_CC_EN] && !ctrl_q[CTL_CC_CLEAR] && i_cc_pulse
    |=> cc_q == ($past(i_cc_up) ? $past(cc_q) + 16'h0001
                 : $past(cc_q) - 16'h0001))
    else $error("charge count step wrong");
  chk_snap_low: assert property (
    rd_stb && rd_addr == ADDR_CC_RAW_HI
    |=> snap_raw_q == $past(cc_q[7:0]))
    else $error("low byte not captured");
  chk_touch_gain: assert property (
    start_now && ent_ch >= CH_GP_FIRST && ent_ch <= CH_TOUCH_LAST
    && ent_bias != BIAS_NONE
    |=> !o_gain_ten && o_touch_reference_supply_en)
    else $error("touch gain or reference wrong");
  chk_signed_chan: assert property (
    o_result_valid |-> o_result_signed == (o_result_chan == CH_CHG_I))
    else $error("sign coding on wrong channel");
  chk_bias_out: assert property (
    start_now && run |=> o_bias == $past(ent_bias))
    else $error("bias not taken from entry");
  cov_round: cover property (flags_q[FLAG_ROUND]);
  cov_pen_int: cover property (flags_q[FLAG_PEN] ##[1:50] o_int);
  cov_write: cover property (wr_stb);
  cov_result: cover property (o_result_valid && o_result_signed);
endmodule

// *** tb/aact_host.sv ***
`timescale 1ns/1ps
// ********************
// Host side of the SPI link, mode 0, MSB first
// ********************
module aact_host #(
  parameter int HALF = 8
) (
  input wire logic i_sys_clk,
  input wire logic i_miso,
  output logic o_cs_n,
  output logic o_sclk,
  output logic o_mosi
);
  // Idle: deselected, clock parked low
  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b0;
    o_mosi = 1'b0;
  end
  // One 16-bit frame; read data taken on the last eight rises
  task automatic xfer(input logic rd, input logic [6:0] addr,
                      input logic [7:0] data, output logic [7:0] q);
    logic [15:0] word;
    word = {rd, addr, data};
    q = 8'h00;
    @(negedge i_sys_clk);
    o_cs_n = 1'b0;
    repeat (HALF) @(negedge i_sys_clk);
    for (int i = 15; i >= 0; i--) begin
      o_mosi = word[i];
      repeat (HALF) @(negedge i_sys_clk);
      o_sclk = 1'b1;
      if (i < 8) begin
        q = {q[6:0], i_miso};
      end
      repeat (HALF) @(negedge i_sys_clk);
      o_sclk = 1'b0;
    end
    repeat (HALF) @(negedge i_sys_clk);
    o_cs_n = 1'b1;
    o_mosi = ~o_mosi; // Released line shows no stale level
    repeat (HALF) @(negedge i_sys_clk);
  endtask
endmodule

// *** tb/aact_top_bench.sv ***
`timescale 1ns/1ps
module aact_top_bench;
  import aact_pkg::*;
  typedef struct packed {
    logic [7:0] entry;
    logic [7:0] glo;
    logic [7:0] ghi;
    logic [7:0] vnd;
    logic [9:0] code;
    logic gain;
    logic touch_reference_supply;
    logic sgn;
  } aact_row_t;
  // Entry, gain lo/hi, vendor, code, gain, touch_reference_supply, signed
  localparam aact_row_t ROWS [10] = '{
    '{8'h0A, 8'h01, 8'h00, 8'h00, 10'h3FF, 1'b1, 1'b0, 1'b0},
    '{8'h0A, 8'h00, 8'h00, 8'h00, 10'h1FF, 1'b0, 1'b0, 1'b0},
    '{8'h15, 8'h00, 8'h08, 8'h00, 10'h155, 1'b1, 1'b0, 1'b0},
    '{8'h4C, 8'h04, 8'h00, 8'h00, 10'h3FF, 1'b0, 1'b1, 1'b0},
    '{8'h2D, 8'h00, 8'h00, 8'h00, 10'h123, 1'b0, 1'b1, 1'b0},
    '{8'h0E, 8'h00, 8'h00, 8'h00, 10'h000, 1'b0, 1'b0, 1'b0},
    '{8'h16, 8'h00, 8'h00, 8'h01, 10'h3FF, 1'b0, 1'b0, 1'b0},
    '{8'h18, 8'h00, 8'h00, 8'h02, 10'h200, 1'b0, 1'b0, 1'b1},
    '{8'h19, 8'h00, 8'h00, 8'h04, 10'h200, 1'b0, 1'b0, 1'b0},
    '{8'h1A, 8'h00, 8'h00, 8'h08, 10'h015, 1'b0, 1'b0, 1'b0}};
  logic i_sys_clk = 1'b0;
  logic i_reset = 1'b1;
  logic cs_n, sclk, mosi, o_spi_miso, o_spi_miso_oe;
  logic i_pen_touch = 1'b0;
  logic i_conv_valid = 1'b0;
  logic [9:0] i_conv_code = 10'h000;
  logic i_cc_pulse = 1'b0;
  logic i_cc_up = 1'b0;
  logic o_conv_start, o_gain_ten, o_touch_reference_supply_en, o_pen_bias_en;
  logic o_result_valid, o_result_signed, o_result_gain, o_int;
  logic [4:0] o_chan_sel, o_result_chan;
  logic [2:0] o_bias;
  logic [3:0] o_dedicated_en;
  logic [9:0] o_result_code;
  int n_fail = 0;
  int checks_done = 0;
  int cycles = 0;
  int starts;
  aact_row_t r;
  always #5 i_sys_clk = ~i_sys_clk;
  aact_top u_aact_top (.i_sys_clk(i_sys_clk), .i_reset(i_reset),
    .i_spi_cs_n(cs_n), .i_spi_sclk(sclk), .i_spi_mosi(mosi),
    .o_spi_miso(o_spi_miso), .o_spi_miso_oe(o_spi_miso_oe),
    .i_pen_touch(i_pen_touch), .i_conv_valid(i_conv_valid),
    .i_conv_code(i_conv_code), .i_cc_pulse(i_cc_pulse),
    .i_cc_up(i_cc_up), .o_conv_start(o_conv_start),
    .o_chan_sel(o_chan_sel), .o_bias(o_bias), .o_gain_ten(o_gain_ten),
    .o_touch_reference_supply_en(o_touch_reference_supply_en), .o_pen_bias_en(o_pen_bias_en),
    .o_dedicated_en(o_dedicated_en), .o_result_valid(o_result_valid),
    .o_result_chan(o_result_chan), .o_result_code(o_result_code),
    .o_result_signed(o_result_signed), .o_result_gain(o_result_gain),
    .o_int(o_int));
  aact_host u_aact_host (.i_sys_clk(i_sys_clk), .i_miso(o_spi_miso),
    .o_cs_n(cs_n), .o_sclk(sclk), .o_mosi(mosi));
  // ********************
  // Converter model and run limit
  // ********************
  always begin
    @(negedge i_sys_clk);
    if (o_conv_start === 1'b1) begin
      repeat (3) @(negedge i_sys_clk);
      i_conv_valid = 1'b1;
      @(negedge i_sys_clk);
      i_conv_valid = 1'b0;
    end
  end
  always @(posedge i_sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      n_fail++;
      summarize();
    end
  end
  // ********************
  // Shared tasks
  // ********************
  task automatic chk(input string nm, input logic [15:0] exp,
                     input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] q;
    u_aact_host.xfer(1'b0, a, d, q);
  endtask
  task automatic rchk(input string nm, input logic [6:0] a,
                      input logic [7:0] exp);
    logic [7:0] q;
    u_aact_host.xfer(1'b1, a, 8'h00, q);
    chk(nm, exp, q);
  endtask
  task automatic cc_step(input logic up, input int n);
    repeat (n) begin
      i_cc_up = up;
      i_cc_pulse = 1'b1;
      @(negedge i_sys_clk);
      i_cc_pulse = 1'b0;
      @(negedge i_sys_clk);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ********************
  // Main sequence
  // ********************
  initial begin
    repeat (8) @(negedge i_sys_clk);
    i_reset = 1'b0;
    repeat (8) @(negedge i_sys_clk);
    chk("chan_sel reset", 16'h001F, o_chan_sel);
    chk("int reset", 16'h0000, o_int);
    chk("miso_oe reset", 16'h0000, o_spi_miso_oe);
    rchk("entry reset", ADDR_RR_BASE, RR_RESET);
    rchk("flags reset", ADDR_INT_FLAGS, 8'h00);
    rchk("unmapped", 7'h10, 8'h00);
    $display("reset test done");
    foreach (ROWS[k]) begin
      r = ROWS[k];
      wr(ADDR_GAIN_LO, r.glo);
      wr(ADDR_GAIN_HI, r.ghi);
      wr(ADDR_VENDOR, r.vnd);
      wr(ADDR_RR_BASE, r.entry);
      i_conv_code = r.code;
      wr(ADDR_CTRL_ONE, 8'hC0);
      for (int i = 0; i < 800 && o_result_valid !== 1'b1; i++)
        @(negedge i_sys_clk);
      chk("dedicated_en", {12'h000, r.vnd[3:0]}, o_dedicated_en);
      chk("result_chan", r.entry[4:0], o_result_chan);
      chk("chan_sel", r.entry[4:0], o_chan_sel);
      chk("result_code", r.code, o_result_code);
      chk("result_gain", r.gain, o_result_gain);
      chk("result_signed", r.sgn, o_result_signed);
      chk("bias", r.entry[7:5], o_bias);
      chk("touch_reference_supply", r.touch_reference_supply, o_touch_reference_supply_en);
      wr(ADDR_CTRL_ONE, 8'h00);
      wr(ADDR_VENDOR, 8'h00);
      $display("row %0d done", k);
    end
    // Disabled supply channel must never start
    wr(ADDR_RR_BASE, 8'h16);
    wr(ADDR_CTRL_ONE, 8'hC0);
    starts = 0;
    repeat (300) begin
      @(negedge i_sys_clk);
      starts += (o_conv_start === 1'b1) ? 1 : 0;
    end
    chk("skipped starts", 16'h0000, starts[15:0]);
    wr(ADDR_CTRL_ONE, 8'h00);
    $display("skip test done");
    // Pen touch with bias enabled, then masked and cleared
    wr(ADDR_INT_MASKS, 8'h05);
    wr(ADDR_RR_BASE, 8'h0E);
    wr(ADDR_CTRL_ONE, 8'hE0);
    i_pen_touch = 1'b1;
    for (int i = 0; i < 400 && o_int !== 1'b1; i++)
      @(negedge i_sys_clk);
    chk("int raised", 16'h0001, o_int);
    chk("pen bias", 16'h0001, o_pen_bias_en);
    // Round flag also set, the loop keeps running
    rchk("pen flag", ADDR_INT_FLAGS, 8'h03);
    i_pen_touch = 1'b0;
    wr(ADDR_INT_MASKS, 8'h07);
    chk("int masked", 16'h0000, o_int);
    wr(ADDR_CTRL_ONE, 8'h00);
    wr(ADDR_INT_FLAGS, 8'h07);
    rchk("flags clear", ADDR_INT_FLAGS, 8'h00);
    $display("pen test done");
    // Charge counter: gated, signed, raw, snapshot, clear
    cc_step(1'b1, 3);
    rchk("cc off hi", ADDR_CC_SIGNED_HI, 8'h00);
    rchk("cc off", ADDR_CC_SIGNED_LO, 8'h00);
    wr(ADDR_CTRL_ONE, 8'h08);
    cc_step(1'b1, 3);
    cc_step(1'b0, 5);
    rchk("raw hi", ADDR_CC_RAW_HI, 8'hFF);
    rchk("raw lo", ADDR_CC_RAW_LO, 8'hFE);
    rchk("signed hi", ADDR_CC_SIGNED_HI, 8'hFF);
    cc_step(1'b1, 4);
    rchk("snapshot lo", ADDR_CC_SIGNED_LO, 8'hFE);
    wr(ADDR_CC_SIGNED_HI, 8'h55);
    rchk("ro hi", ADDR_CC_SIGNED_HI, 8'h00);
    rchk("new lo", ADDR_CC_SIGNED_LO, 8'h02);
    wr(ADDR_CTRL_ONE, 8'h18);
    rchk("cleared hi", ADDR_CC_RAW_HI, 8'h00);
    rchk("cleared lo", ADDR_CC_RAW_LO, 8'h00);
    $display("charge test done");
    summarize();
  end
endmodule
